//--- logic/i2c_expander_regs.svh
/*
  Register codes, reset values and field positions of the I/O expander.
  Assumes it is included by the package and by the design file.
*/
`ifndef I2C_EXPANDER_REGS_SVH
`define I2C_EXPANDER_REGS_SVH
// ---------------------------------------------------------------
// register codes
// ---------------------------------------------------------------
`define REG_IN_LOW 3'h0
`define REG_IN_HIGH 3'h1
`define REG_OUT_LOW 3'h2
`define REG_OUT_HIGH 3'h3
`define REG_INV_LOW 3'h4
`define REG_INV_HIGH 3'h5
`define REG_DIR_LOW 3'h6
`define REG_DIR_HIGH 3'h7
`define PAIR_IN 2'h0
`define PAIR_OUT 2'h1
`define PAIR_INV 2'h2
`define PAIR_DIR 2'h3
// ---------------------------------------------------------------
// reset values and bus constants
// ---------------------------------------------------------------
`define RST_LATCH 8'hff
`define RST_INVERT 8'h00
`define RST_DIR 8'hff
`define DEV_ADDR_FIXED 4'h4
`define GEN_CALL_ADDR 7'h00
`define BITS_PER_BYTE 4'h8
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1
// ---------------------------------------------------------------
// synchroniser layout: scl, sda, address select, pins
// ---------------------------------------------------------------
`define SYNC_W 21
`define SYNC_SCL 0
`define SYNC_SDA 1
`define SYNC_ADDR 2
`define SYNC_PINS 5
`define SYNC_RST 21'h000003
`endif

//--- logic/i2c_expander_pkg.sv
/*
  Types of the I/O expander: bus states and the state record.
  Assumes the register header sits in the include path.
*/
`include "i2c_expander_regs.svh"
package i2c_expander_pkg;
  // gray steps along address, write and read paths
  typedef enum logic [2:0] {
    st_idle = 3'h0,
    st_addr = 3'h1,
    st_ack_addr = 3'h3,
    st_write = 3'h2,
    st_ack_write = 3'h6,
    st_read = 3'h7,
    st_ack_read = 3'h5,
    st_ignore = 3'h4
  } bus_state_e;
  typedef logic [`SYNC_W-1:0] sync_t;
  typedef struct packed {
    sync_t s1;
    sync_t s2;
    sync_t s3;
    sync_t f;
    bus_state_e st;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic rw;
    logic first;
    logic acked;
    logic drive;
    logic [2:0] ptr;
    logic [1:0][7:0] latch;
    logic [1:0][7:0] invert;
    logic [1:0][7:0] dir;
  } expander_state_s;
endpackage

//--- logic/i2c_io_expander_slave.sv
/*
  Serial slave front end and register file of a 16-bit I/O expander.
  Assumes scl, sda, address select and pins are asynchronous to
  clock_i and much slower than it; sda is open drain, resolved
  outside from sda_oe_n_o.
*/
// Overview of operation
// - input direction turns both pin drivers off, pin floats.
// - output direction drives the pin high or low from its latch.
// - after reset every pin is an input.
// - reset returns every register to its default.
// - start is sda falling with scl high; address reception follows.
// - the general call address is never acknowledged.
// - own address is acknowledged by sda low over the ninth high phase.
// - sda changes only while scl is low; else start or stop.
// - stop is sda rising with scl high; device returns to idle.
// - each byte is eight bits plus one acknowledge bit, any count.
// - transmitter releases sda after the eighth bit for the acknowledge.
// - device acknowledges written bytes; master acks all reads but last.
// - master nack ends a read; device then releases sda.
// - address is 0100 followed by the three select inputs.
// - direction bit 1 reads from the device, 0 writes to it.
// - first written byte after the address is the command.
// - command bytes come only in writes; reads reuse the stored one.
// - reads keep using the stored command until a new one arrives.
// - codes 0-1 input, 2-3 latch, 4-5 polarity, 6-7 direction.
// - latch and direction reset to ones, polarity to zeros.
// - after each data byte the pointer moves to the pair partner.
// - direction bit 1 makes an input, 0 an output.
// - polarity bit 1 inverts the reported input value.
// - input registers show pin levels, ignore writes; latches read back.
`timescale 1ns/1ps
`include "i2c_expander_regs.svh"
module i2c_io_expander_slave (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic addr_select_bit_zero_i,
  input wire logic addr_select_bit_one_i,
  input wire logic addr_select_bit_two_i,
  input wire logic [7:0] low_port_pins_i,
  output logic [7:0] low_port_pins_o,
  output logic [7:0] low_port_pins_oe_n_o,
  input wire logic [7:0] high_port_pins_i,
  output logic [7:0] high_port_pins_o,
  output logic [7:0] high_port_pins_oe_n_o
);
  import i2c_expander_pkg::*;

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic [1:0] rst_q;
  logic rst_n;

  // two stages so release never lands mid-edge of the state flops
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_q <= 2'h0;
    end else if (clk_en_i) begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // ---------------------------------------------------------------
  // input filtering and bus events
  // ---------------------------------------------------------------
  expander_state_s cur;
  expander_state_s nxt;
  sync_t raw;
  sync_t agree;
  sync_t filt_next;
  logic scl_now;
  logic scl_new;
  logic sda_now;
  logic sda_new;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic [2:0] addr_f;
  logic [15:0] in_level;
  logic addr_hit;
  logic byte_end;
  logic [7:0] rd_value;

  // pins and select lines share the scl/sda chain
  assign raw = {high_port_pins_i, low_port_pins_i,
                addr_select_bit_two_i, addr_select_bit_one_i,
                addr_select_bit_zero_i, sda_i, scl_i};

  // a level counts once stages two and three agree
  assign agree = ~(cur.s2 ^ cur.s3);
  assign filt_next = (cur.s3 & agree) | (cur.f & ~agree);

  assign scl_now = cur.f[`SYNC_SCL];
  assign scl_new = filt_next[`SYNC_SCL];
  assign sda_now = cur.f[`SYNC_SDA];
  assign sda_new = filt_next[`SYNC_SDA];
  assign scl_rise = clk_en_i & ~scl_now & scl_new;
  assign scl_fall = clk_en_i & scl_now & ~scl_new;
  // sda moving under a high scl is a bus condition
  assign start_ev = clk_en_i & scl_now & scl_new & sda_now & ~sda_new;
  assign stop_ev = clk_en_i & scl_now & scl_new & ~sda_now & sda_new;
  assign addr_f = cur.f[`SYNC_ADDR +: 3];
  assign in_level = cur.f[`SYNC_PINS +: 16];
  assign byte_end = scl_fall & (cur.cnt == `BITS_PER_BYTE);

  // fixed upper nibble, select inputs below; general call never hits
  assign addr_hit = (cur.shift[7:1] == {`DEV_ADDR_FIXED, addr_f});

  // ---------------------------------------------------------------
  // read data selection
  // ---------------------------------------------------------------
  // inputs report pin level whatever the direction; latch reads back
  always_comb begin
    case (cur.ptr[2:1])
      `PAIR_IN: begin
        rd_value = cur.ptr[0] ? in_level[15:8] ^ cur.invert[1]
                              : in_level[7:0] ^ cur.invert[0];
      end
      `PAIR_OUT: begin
        rd_value = cur.latch[cur.ptr[0]];
      end
      `PAIR_INV: begin
        rd_value = cur.invert[cur.ptr[0]];
      end
      default: begin
        rd_value = cur.dir[cur.ptr[0]];
      end
    endcase
  end

  // ---------------------------------------------------------------
  // bus state machine and register writes
  // ---------------------------------------------------------------
  always_comb begin
    nxt = cur;
    nxt.s1 = raw;
    nxt.s2 = cur.s1;
    nxt.s3 = cur.s2;
    nxt.f = filt_next;
    case (cur.st)
      st_addr: begin
        if (scl_rise) begin
          nxt.shift = {cur.shift[6:0], sda_new};
          nxt.cnt = cur.cnt + `CNT_ONE;
        end else if (byte_end) begin
          nxt.rw = cur.shift[0];
          nxt.cnt = `CNT_ZERO;
          if (addr_hit) begin
            nxt.st = st_ack_addr;
            nxt.drive = 1'b1;
          end else begin
            nxt.st = st_ignore;
          end
        end
      end
      st_ack_addr: begin
        if (scl_fall) begin
          nxt.cnt = `CNT_ZERO;
          if (cur.rw) begin
            // no command in a read: the stored pointer is used
            nxt.tx = rd_value;
            nxt.drive = ~rd_value[7];
            nxt.st = st_read;
          end else begin
            nxt.drive = 1'b0;
            nxt.first = 1'b1;
            nxt.st = st_write;
          end
        end
      end
      st_write: begin
        if (scl_rise) begin
          nxt.shift = {cur.shift[6:0], sda_new};
          nxt.cnt = cur.cnt + `CNT_ONE;
        end else if (byte_end) begin
          nxt.st = st_ack_write;
          nxt.drive = 1'b1;
          nxt.cnt = `CNT_ZERO;
          if (cur.first) begin
            nxt.first = 1'b0;
            nxt.ptr = cur.shift[2:0];
          end else begin
            nxt.ptr[0] = ~cur.ptr[0];
            case (cur.ptr[2:1])
              `PAIR_OUT: begin
                nxt.latch[cur.ptr[0]] = cur.shift;
              end
              `PAIR_INV: begin
                nxt.invert[cur.ptr[0]] = cur.shift;
              end
              `PAIR_DIR: begin
                nxt.dir[cur.ptr[0]] = cur.shift;
              end
              default: begin
                nxt.ptr[0] = ~cur.ptr[0];
              end
            endcase
          end
        end
      end
      st_ack_write: begin
        if (scl_fall) begin
          nxt.drive = 1'b0;
          nxt.st = st_write;
        end
      end
      st_read: begin
        if (scl_rise) begin
          nxt.cnt = cur.cnt + `CNT_ONE;
        end else if (byte_end) begin
          // release for the master's acknowledge slot
          nxt.drive = 1'b0;
          nxt.ptr[0] = ~cur.ptr[0];
          nxt.cnt = `CNT_ZERO;
          nxt.st = st_ack_read;
        end else if (scl_fall) begin
          nxt.tx = {cur.tx[6:0], 1'b0};
          nxt.drive = ~cur.tx[6];
        end
      end
      st_ack_read: begin
        if (scl_rise) begin
          nxt.acked = ~sda_new;
        end else if (scl_fall) begin
          if (cur.acked) begin
            nxt.tx = rd_value;
            nxt.drive = ~rd_value[7];
            nxt.st = st_read;
          end else begin
            nxt.st = st_ignore;
          end
        end
      end
      default: begin
        nxt.drive = 1'b0;
      end
    endcase
    // bus conditions override any byte in progress
    if (start_ev) begin
      nxt.st = st_addr;
      nxt.cnt = `CNT_ZERO;
      nxt.drive = 1'b0;
    end
    if (stop_ev) begin
      nxt.st = st_idle;
      nxt.drive = 1'b0;
    end
  end

  // all state but the reset stages in one record; clock enable freezes it
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
      cur.s1 <= `SYNC_RST;
      cur.s2 <= `SYNC_RST;
      cur.s3 <= `SYNC_RST;
      cur.f <= `SYNC_RST;
      cur.latch <= {2{`RST_LATCH}};
      cur.invert <= {2{`RST_INVERT}};
      cur.dir <= {2{`RST_DIR}};
    end else if (clk_en_i) begin
      cur <= nxt;
    end
  end

  // ---------------------------------------------------------------
  // pin and bus drivers
  // ---------------------------------------------------------------
  // open drain: only ever pull low
  assign sda_o = 1'b0;
  assign sda_oe_n_o = ~cur.drive;
  // direction one floats the pin, zero drives the latch level
  assign low_port_pins_oe_n_o = cur.dir[0];
  assign high_port_pins_oe_n_o = cur.dir[1];
  assign low_port_pins_o = cur.latch[0] & ~cur.dir[0];
  assign high_port_pins_o = cur.latch[1] & ~cur.dir[1];

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n);

  sequence s_addr_end;
    cur.st == st_addr && byte_end;
  endsequence
  sequence s_wr_end;
    cur.st == st_write && byte_end;
  endsequence
  sequence s_rd_load;
    cur.st == st_ack_addr && scl_fall && cur.rw;
  endsequence

  // reset values and pin drivers
  a_reset_defaults: assert property ($rose(rst_n) |->
    low_port_pins_oe_n_o == `RST_DIR && high_port_pins_oe_n_o == `RST_DIR
    && cur.latch[0] == `RST_LATCH && cur.latch[1] == `RST_LATCH
    && cur.invert[0] == `RST_INVERT && cur.invert[1] == `RST_INVERT)
    else $error("register defaults wrong after reset");
  a_pin_drive: assert property (
    low_port_pins_oe_n_o == cur.dir[0]
    && high_port_pins_oe_n_o == cur.dir[1]
    && ((low_port_pins_o ^ cur.latch[0]) & ~cur.dir[0]) == 8'h00
    && ((high_port_pins_o ^ cur.latch[1]) & ~cur.dir[1]) == 8'h00
    && (low_port_pins_o & low_port_pins_oe_n_o) == 8'h00
    && (high_port_pins_o & high_port_pins_oe_n_o) == 8'h00)
    else $error("pin drivers disagree with direction");
  // bus conditions and acknowledges
  a_start_addr: assert property (start_ev |=> cur.st == st_addr
    && cur.cnt == `CNT_ZERO && !cur.drive)
    else $error("start did not open address phase");
  a_stop_idle: assert property (stop_ev |=>
    cur.st == st_idle && sda_oe_n_o)
    else $error("stop did not return to idle");
  a_drive_scl_low: assert property (
    $rose(cur.drive) |-> !cur.f[`SYNC_SCL])
    else $error("sda pulled while scl high");
  a_addr_ack: assert property (s_addr_end ##0 addr_hit |=>
    !sda_oe_n_o && cur.st == st_ack_addr)
    else $error("own address not acknowledged");
  a_general_call: assert property (s_addr_end ##0
    (cur.shift[7:1] == `GEN_CALL_ADDR) |=>
    cur.st == st_ignore && sda_oe_n_o)
    else $error("general call answered");
  a_ack_held: assert property (
    cur.st == st_ack_addr || cur.st == st_ack_write |-> !sda_oe_n_o)
    else $error("acknowledge released early");
  a_ack_write: assert property (s_wr_end |=>
    !sda_oe_n_o && cur.st == st_ack_write)
    else $error("written byte not acknowledged");
  // command, pointer and register writes
  a_cmd_store: assert property (s_wr_end ##0 cur.first |=>
    {5'h00, cur.ptr} == ($past(cur.shift) & 8'h07) && !cur.first)
    else $error("command byte not stored");
  a_ptr_toggle: assert property (s_wr_end ##0 !cur.first |=>
    cur.ptr == ($past(cur.ptr) ^ 3'h1))
    else $error("pointer did not move to partner");
  a_latch_write: assert property (s_wr_end ##0
    (!cur.first && cur.ptr == `REG_OUT_LOW) |=>
    cur.latch[0] == $past(cur.shift))
    else $error("write missed the low latch");
  a_in_write_ignored: assert property (s_wr_end ##0
    (!cur.first && cur.ptr[2:1] == `PAIR_IN) |=> $stable(cur.latch)
    && $stable(cur.invert) && $stable(cur.dir))
    else $error("write to input register took effect");
  // read data and release of sda
  a_read_invert: assert property (s_rd_load ##0
    (cur.ptr == `REG_IN_LOW) |=> {8'h00, cur.tx}
    == (($past(in_level) & 16'h00ff) ^ {8'h00, cur.invert[0]}))
    else $error("input read ignores polarity");
  a_read_latch: assert property (s_rd_load ##0
    (cur.ptr == `REG_OUT_HIGH) |=> cur.tx == cur.latch[1])
    else $error("latch read returned wrong value");
  a_read_release: assert property (cur.st == st_read && byte_end |=>
    sda_oe_n_o ##0 cur.st == st_ack_read)
    else $error("sda held after eighth read bit");
  a_read_toggle: assert property (cur.st == st_read && byte_end |=>
    cur.ptr == ($past(cur.ptr) ^ 3'h1))
    else $error("read pointer did not move to partner");
  a_nack_release: assert property (cur.st == st_ack_read && scl_fall
    && !cur.acked |=> (cur.st == st_ignore && sda_oe_n_o) [*2])
    else $error("sda held after master nack");
endmodule

//--- test/i2c_master_model.sv
/*
  Bus master model for the expander: start, stop, byte write, byte read.
  Assumes sda_i is the resolved open-drain line with a pull-up and that
  the caller waits at least one frame gap between transactions.
*/
`timescale 1ns/1ps
module i2c_master_model (
  input wire logic clock_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // ---------------------------------------------------------------
  // bus timing: 20 clocks a bit, scl stands high between frames
  // ---------------------------------------------------------------
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // start or repeated start: sda falls while scl is high
  task automatic start();
    sda_o <= 1'b1;
    tick(5);
    scl_o <= 1'b1;
    tick(5);
    sda_o <= 1'b0;
    tick(5);
    scl_o <= 1'b0;
  endtask
  // stop: sda rises while scl is high
  task automatic stop();
    tick(5);
    sda_o <= 1'b0;
    tick(5);
    scl_o <= 1'b1;
    tick(5);
    sda_o <= 1'b1;
    tick(10);
  endtask
  // one bit; sda moves mid-low, sampled mid-high
  task automatic bit_io(input logic b, output logic s);
    tick(5);
    sda_o <= b;
    tick(5);
    scl_o <= 1'b1;
    tick(5);
    s = sda_i;
    tick(5);
    scl_o <= 1'b0;
  endtask
  // msb first, then release for the receiver's acknowledge
  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, ack);
  endtask
  // a nack on the last byte leaves sda high for the stop
  task automatic read_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(nack, s);
  endtask
endmodule

//--- test/testbench.sv
/*
  Self-checking bench of the expander slave through its serial bus.
  Assumes the master model drives scl and sda; pins resolve outside.
*/
`timescale 1ns/1ps
module testbench;
  logic clock_i, nrst_i, clk_en_i, ack;
  logic [2:0] asel;
  logic [7:0] ext_lo, ext_hi, r0, r1;
  wire scl, m_sda, dev_sda, sda_oe_n;
  wire [7:0] lo_o, lo_oe_n, hi_o, hi_oe_n;
  int err_total = 0;
  int comparisons = 0;
  // ---------------------------------------------------------------
  // wiring: open-drain sda with pull-up, pins from driver or outside
  // ---------------------------------------------------------------
  wire sda = m_sda & (sda_oe_n | dev_sda);
  wire [7:0] lo_lvl = (ext_lo & lo_oe_n) | (lo_o & ~lo_oe_n);
  wire [7:0] hi_lvl = (ext_hi & hi_oe_n) | (hi_o & ~hi_oe_n);
  i2c_master_model u_i2c_master_model (.clock_i(clock_i), .sda_i(sda),
    .scl_o(scl), .sda_o(m_sda));
  i2c_io_expander_slave u_i2c_io_expander_slave (.clock_i(clock_i),
    .nrst_i(nrst_i), .clk_en_i(clk_en_i), .scl_i(scl), .sda_i(sda),
    .sda_o(dev_sda), .sda_oe_n_o(sda_oe_n),
    .addr_select_bit_zero_i(asel[0]), .addr_select_bit_one_i(asel[1]),
    .addr_select_bit_two_i(asel[2]), .low_port_pins_i(lo_lvl),
    .low_port_pins_o(lo_o), .low_port_pins_oe_n_o(lo_oe_n),
    .high_port_pins_i(hi_lvl), .high_port_pins_o(hi_o),
    .high_port_pins_oe_n_o(hi_oe_n));
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // ---------------------------------------------------------------
  // comparison, verdict and bus helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // address byte plus its acknowledge, expected ack level given
  task automatic addr(input logic [7:0] a, input logic exp);
    u_i2c_master_model.start();
    u_i2c_master_model.write_byte(a, ack);
    check({7'h0, ack}, {7'h0, exp}, "address ack");
  endtask
  task automatic wr(input logic [7:0] cmd, d0, d1);
    addr({4'h4, asel, 1'b0}, 1'b0);
    u_i2c_master_model.write_byte(cmd, ack);
    check({7'h0, ack}, 8'h00, "command ack");
    u_i2c_master_model.write_byte(d0, ack);
    check({7'h0, ack}, 8'h00, "data ack");
    u_i2c_master_model.write_byte(d1, ack);
    check({7'h0, ack}, 8'h00, "data ack");
    u_i2c_master_model.stop();
  endtask
  // reads two bytes; without a command the stored pointer is used
  task automatic rd(input logic [7:0] cmd, input logic send_cmd);
    if (send_cmd) begin
      addr({4'h4, asel, 1'b0}, 1'b0);
      u_i2c_master_model.write_byte(cmd, ack);
    end
    addr({4'h4, asel, 1'b1}, 1'b0);
    u_i2c_master_model.read_byte(1'b0, r0);
    u_i2c_master_model.read_byte(1'b1, r1);
    u_i2c_master_model.stop();
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_defaults();
    check(lo_oe_n, 8'hff, "low dir after reset");
    check(hi_oe_n, 8'hff, "high dir after reset");
    check(lo_o | hi_o, 8'h00, "pins undriven");
    check({7'h0, sda_oe_n}, 8'h01, "sda released");
    check({7'h0, dev_sda}, 8'h00, "sda pulls low only");
    rd(8'h03, 1'b1);
    check(r0, 8'hff, "latch high default");
    check(r1, 8'hff, "latch low default");
    rd(8'h04, 1'b1);
    check(r0 | r1, 8'h00, "polarity default");
    rd(8'h07, 1'b1);
    check(r0 & r1, 8'hff, "direction default");
    $display("test defaults done");
  endtask
  task automatic t_outputs();
    wr(8'h03, 8'h5a, 8'ha5);
    wr(8'hfe, 8'h0f, 8'hc3);
    check(lo_oe_n, 8'h0f, "low driver enables");
    check(hi_oe_n, 8'hc3, "high driver enables");
    check(lo_o, 8'ha0, "low driven levels");
    check(hi_o, 8'h18, "high driven levels");
    rd(8'h02, 1'b1);
    check(r0, 8'ha5, "latch low readback");
    check(r1, 8'h5a, "latch high readback");
    $display("test outputs done");
  endtask
  task automatic t_inputs();
    ext_lo <= 8'h36;
    ext_hi <= 8'h81;
    wr(8'h04, 8'hff, 8'h00);
    rd(8'h00, 1'b1);
    check(r0, 8'h59, "inverted low input");
    check(r1, 8'h99, "plain high input");
    wr(8'h00, 8'h00, 8'h00);
    rd(8'h01, 1'b1);
    check(r0, 8'h99, "input write ignored");
    check(r1, 8'h59, "input write ignored");
    rd(8'h00, 1'b0);
    check(r0, 8'h99, "stored pointer reused");
    check(r1, 8'h59, "stored pointer pair");
    $display("test inputs done");
  endtask
  task automatic t_address();
    for (int a = 0; a < 8; a++) begin
      asel <= a[2:0];
      u_i2c_master_model.tick(10);
      addr({4'h4, a[2:0], 1'b0}, 1'b0);
      u_i2c_master_model.stop();
      addr({4'h4, ~a[2:0], 1'b0}, 1'b1);
      u_i2c_master_model.stop();
    end
    addr(8'h00, 1'b1);
    u_i2c_master_model.stop();
    rd(8'h06, 1'b1);
    check(r0, 8'h0f, "bus alive after refusal");
    $display("test address done");
  endtask
  // a frozen block neither answers nor takes a write
  task automatic t_freeze();
    clk_en_i <= 1'b0;
    u_i2c_master_model.start();
    u_i2c_master_model.write_byte({4'h4, asel, 1'b0}, ack);
    check({7'h0, ack}, 8'h01, "frozen address ignored");
    u_i2c_master_model.write_byte(8'h06, ack);
    u_i2c_master_model.write_byte(8'h00, ack);
    u_i2c_master_model.stop();
    clk_en_i <= 1'b1;
    u_i2c_master_model.tick(8);
    check(lo_oe_n, 8'h0f, "frozen direction kept");
    $display("test freeze done");
  endtask
  // a mid-run reset must undo every write made so far
  task automatic t_reset();
    nrst_i <= 1'b0;
    u_i2c_master_model.tick(4);
    check(lo_oe_n & hi_oe_n, 8'hff, "pins float in reset");
    check(lo_o | hi_o, 8'h00, "no drive in reset");
    nrst_i <= 1'b1;
    u_i2c_master_model.tick(12);
    rd(8'h02, 1'b1);
    check(r0 & r1, 8'hff, "latch back to ones");
    rd(8'h04, 1'b1);
    check(r0 | r1, 8'h00, "polarity back to zeros");
    $display("test reset done");
  endtask
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    clk_en_i = 1'b1;
    nrst_i = 1'b0;
    asel = 3'h2;
    ext_lo = 8'h00;
    ext_hi = 8'h00;
    repeat (4) @(posedge clock_i);
    nrst_i <= 1'b1;
    // filter settles on idle-high before the first frame
    repeat (12) @(posedge clock_i);
    t_defaults();
    t_outputs();
    t_inputs();
    t_address();
    t_freeze();
    t_reset();
    final_report();
  end
  initial begin
    repeat (90000) @(posedge clock_i);
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end
endmodule
